// ---- verilog/pkid_params.svh ----
`ifndef PKID_PARAMS_SVH
`define PKID_PARAMS_SVH
`define PKID_W_FIRST     8'h3f
`define PKID_W_LAST      8'h55
`define PKID_W_MDMA      8'h3f
`define PKID_W_PIO       8'h40
`define PKID_W_MDMA_MIN  8'h41
`define PKID_W_MDMA_REC  8'h42
`define PKID_W_PIO_MIN   8'h43
`define PKID_W_PIO_IORDY 8'h44
`define PKID_W_PKT_REL   8'h47
`define PKID_W_SVC_BSY   8'h48
`define PKID_W_QDEPTH    8'h4b
`define PKID_W_MAJOR     8'h50
`define PKID_W_MINOR     8'h51
`define PKID_W_CMD_SUP   8'h52
`define PKID_W_CMD_SUP2  8'h53
`define PKID_W_CMD_EXT   8'h54
`define PKID_W_CMD_ENA   8'h55
`define PKID_SIG_VALID   16'h4000
`define PKID_MAJOR_MASK  16'h003c
`define PKID_SUP82_MASK  16'h67fb
`define PKID_SUP83_MASK  16'h0031
`define PKID_ENA85_MASK  16'h67fb
`define PKID_WB_ID       32'h00000000
`define PKID_WB_SEL      32'h00000004
`define PKID_WB_DATA     32'h00000008
`define PKID_WB_STAT     32'h0000000c
`define PKID_WORDS       9'h100
`endif

// ---- verilog/pkid_pkg.sv ----
package pkid_pkg;
   typedef enum logic [1:0]
   {
      PKID_IDLE  = 2'b00,
      PKID_BUSY  = 2'b01,
      PKID_DRQ   = 2'b10
   } pkid_state_t;
endpackage

// ---- verilog/pkid_words.sv ----
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "pkid_params.svh"
module pkid_words
   import pkid_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic        ident_cmd_i,
   input  wire logic        data_rd_i,
   input  wire logic        int_dis_i,
   output logic             busy_o,
   output logic             drq_o,
   output logic             intrq_o,
   output logic [15:0]      dd_o,
   input  wire logic [2:0]  mdma_sup_i,
   input  wire logic [1:0]  mdma_mode_i,
   input  wire logic        mdma_en_i,
   input  wire logic [7:0]  pio_sup_i,
   input  wire logic [15:0] mdma_min_ns_i,
   input  wire logic [15:0] mdma_rec_ns_i,
   input  wire logic [15:0] pio_min_ns_i,
   input  wire logic [15:0] pio_iordy_ns_i,
   input  wire logic [15:0] pkt_rel_ns_i,
   input  wire logic [15:0] svc_bsy_ns_i,
   input  wire logic [4:0]  qdepth_m1_i,
   input  wire logic [15:0] major_i,
   input  wire logic [15:0] minor_i,
   input  wire logic [15:0] cmd_sup_i,
   input  wire logic [15:0] cmd_sup2_i,
   input  wire logic [15:0] cmd_ena_i
);
   // ********************************************
   // word image
   // ********************************************
   logic [7:0]  word_idx;
   logic [15:0] next_word;
   logic [2:0]  mdma_sel;
   pkid_state_t state;
   logic [8:0]  rd_cnt;
   logic [7:0]  sw_idx;
   logic        rd_q;
   logic        rd_pulse;

   // selected bit only for a supported mode, so never above the top mode
   always_comb
   begin
      mdma_sel = 3'h0;
      // a higher support bit also covers the lower modes
      if (mdma_en_i && ((mdma_sup_i >> mdma_mode_i) != 3'h0) && mdma_mode_i != 2'h3)
         mdma_sel[mdma_mode_i] = 1'b1;
   end

   // reserved fields forced to zero here, not trusted to the sources
   function automatic logic [15:0] pkid_word(input logic [7:0] w);
      logic [15:0] v;
      v = 16'h0000;
      case (w)
         `PKID_W_MDMA:      v = {5'h00, mdma_sel, 5'h00, mdma_sup_i};
         `PKID_W_PIO:       v = {8'h00, pio_sup_i};
         `PKID_W_MDMA_MIN:  v = mdma_min_ns_i;
         `PKID_W_MDMA_REC:  v = mdma_rec_ns_i;
         `PKID_W_PIO_MIN:   v = pio_min_ns_i;
         `PKID_W_PIO_IORDY: v = pio_iordy_ns_i;
         `PKID_W_PKT_REL:   v = pkt_rel_ns_i;
         `PKID_W_SVC_BSY:   v = svc_bsy_ns_i;
         `PKID_W_QDEPTH:    v = {11'h000, qdepth_m1_i};
         `PKID_W_MAJOR:     v = (major_i == 16'h0000 || major_i == 16'hffff) ? major_i
                                : (major_i & `PKID_MAJOR_MASK);
         `PKID_W_MINOR:     v = minor_i;
         `PKID_W_CMD_SUP:   v = cmd_sup_i & `PKID_SUP82_MASK;
         `PKID_W_CMD_SUP2:  v = `PKID_SIG_VALID | (cmd_sup2_i & `PKID_SUP83_MASK);
         `PKID_W_CMD_EXT:   v = `PKID_SIG_VALID;
         `PKID_W_CMD_ENA:   v = cmd_ena_i & `PKID_ENA85_MASK;
         default:           v = 16'h0000;
      endcase
      return v;
   endfunction

   assign word_idx  = rd_cnt[7:0];
   assign next_word = pkid_word(word_idx);

   // ********************************************
   // identify sequence
   // ********************************************
   assign rd_pulse = data_rd_i && !rd_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rd_q <= 1'b0;
      else
         rd_q <= data_rd_i;
   end

   // busy holds one cycle while the first word is latched
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state   <= PKID_IDLE;
         rd_cnt  <= 9'h000;
         intrq_o <= 1'b0;
      end
      else
      begin
         case (state)
            PKID_IDLE:
               if (ident_cmd_i)
               begin
                  state  <= PKID_BUSY;
                  rd_cnt <= 9'h000;
               end
            PKID_BUSY:
            begin
               state   <= PKID_DRQ;
               intrq_o <= !int_dis_i;
            end
            PKID_DRQ:
               if (rd_pulse)
               begin
                  intrq_o <= 1'b0;
                  rd_cnt  <= rd_cnt + 9'h001;
                  if (rd_cnt == `PKID_WORDS - 9'h001)
                     state <= PKID_IDLE;
               end
            default:
               state <= PKID_IDLE;
         endcase
      end
   end

   assign busy_o = (state == PKID_BUSY);
   assign drq_o  = (state == PKID_DRQ);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dd_o <= 16'h0000;
      else
         dd_o <= next_word;
   end

   // ********************************************
   // wishbone slave
   // ********************************************
   logic        wb_hit;
   logic [15:0] sw_word;

   assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign sw_word = pkid_word(sw_idx);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sw_idx <= `PKID_W_FIRST;
      else if (wb_hit && wb_we_i && wb_adr_i == `PKID_WB_SEL && wb_sel_i[0])
         sw_idx <= wb_dat_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         if (wb_hit)
         begin
            case (wb_adr_i)
               `PKID_WB_ID:   begin wb_ack_o <= 1'b1; wb_dat_o <= 32'h00000000; end
               `PKID_WB_SEL:  begin wb_ack_o <= 1'b1; wb_dat_o <= {24'h000000, sw_idx}; end
               `PKID_WB_DATA: begin wb_ack_o <= 1'b1; wb_dat_o <= {16'h0000, sw_word}; end
               `PKID_WB_STAT: begin wb_ack_o <= 1'b1;
                                 wb_dat_o <= {20'h00000, 1'b0, rd_cnt, busy_o, drq_o}; end
               default:       begin wb_err_o <= 1'b1; wb_dat_o <= 32'h00000000; end
            endcase
         end
      end
   end

   // ********************************************
   // checks
   // ********************************************
   chk_sel_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot0(pkid_word(`PKID_W_MDMA) >> 8)) else $error("mdma select not one-hot");
   chk_sel_supported: assert property (@(posedge clk_i) disable iff (rst_i)
      mdma_sel[2] |-> mdma_sup_i[2]) else $error("mode 2 selected unsupported");
   chk_w63_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      (pkid_word(`PKID_W_MDMA) & 16'hf8f8) == 16'h0000) else $error("w63 reserved set");
   chk_w83_sig: assert property (@(posedge clk_i) disable iff (rst_i)
      pkid_word(`PKID_W_CMD_SUP2) [15:14] == 2'b01) else $error("w83 signature bad");
   chk_w84_sig: assert property (@(posedge clk_i) disable iff (rst_i)
      pkid_word(`PKID_W_CMD_EXT) == 16'h4000) else $error("w84 bad");
   chk_w75_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      pkid_word(`PKID_W_QDEPTH) == {11'h000, qdepth_m1_i}) else $error("w75 bad");
   chk_rsvd_word: assert property (@(posedge clk_i) disable iff (rst_i)
      pkid_word(8'h45) == 16'h0000) else $error("reserved word not zero");
   chk_busy_to_drq: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == PKID_IDLE && ident_cmd_i) |=> busy_o ##1 (drq_o && !busy_o)) else $error("busy drq order");
   chk_data_value: assert property (@(posedge clk_i) disable iff (rst_i)
      (word_idx == `PKID_W_MDMA_MIN) |=> dd_o == $past(mdma_min_ns_i)) else $error("w65 value bad");
   chk_busy_single: assert property (@(posedge clk_i) disable iff (rst_i)
      busy_o |=> !busy_o) else $error("busy longer than one cycle");
   chk_intrq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == PKID_BUSY && int_dis_i) |=> !intrq_o) else $error("intrq raised while disabled");
   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   cov_identify: cover property (@(posedge clk_i) disable iff (rst_i) state == PKID_BUSY ##1 drq_o);
   cov_mode_refused: cover property (@(posedge clk_i) disable iff (rst_i)
      mdma_en_i && mdma_mode_i == 2'h2 && !mdma_sel[2]);
   cov_last_word: cover property (@(posedge clk_i) disable iff (rst_i) drq_o && rd_pulse && rd_cnt == 9'h0ff);
   cov_mdma2: cover property (@(posedge clk_i) disable iff (rst_i) mdma_sel[2]);
endmodule // pkid_words

// ---- dv/pkid_host_model.sv ----
`timescale 1ns/1ns
// ********************
// host reading the image
// ********************
module pkid_host_model
(
   input  wire logic        clk_i,
   input  wire logic        start_i,
   input  wire logic [3:0]  gap_i,
   input  wire logic        drq_i,
   input  wire logic        intrq_i,
   input  wire logic [15:0] dd_i,
   output logic             ident_cmd_o,
   output logic             data_rd_o,
   output logic             done_o,
   output logic             irq_seen_o
);
   logic [15:0] img [0:255];
   int          n;
   initial
   begin
      ident_cmd_o = 1'b0;
      data_rd_o   = 1'b0;
      done_o      = 1'b0;
      irq_seen_o  = 1'b0;
      forever
      begin
         @(posedge clk_i);
         if (start_i === 1'b1)
         begin
            done_o      <= 1'b0;
            ident_cmd_o <= 1'b1;
            @(posedge clk_i);
            ident_cmd_o <= 1'b0;
            n = 0;
            while (drq_i !== 1'b1 && n < 20)
            begin
               @(posedge clk_i);
               n++;
            end
            irq_seen_o <= intrq_i;
            // strobe kept low a few cycles so each read is a clean edge
            for (int k = 0; k < 256; k++)
            begin
               img[k] = dd_i;
               data_rd_o <= 1'b1;
               @(posedge clk_i);
               data_rd_o <= 1'b0;
               repeat (3 + gap_i) @(posedge clk_i);
            end
            done_o <= 1'b1;
         end
      end
   end
endmodule // pkid_host_model

// ---- dv/packet_identify_words_63_85_test.sv ----
`timescale 1ns/1ns
module packet_identify_words_63_85_test;
   logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o, wb_err_o;
   logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, q;
   logic [3:0] wb_sel_i = 4'hf, gap = 4'h0;
   logic ident_cmd_i, data_rd_i, int_dis_i = 0, busy_o, drq_o, intrq_o, start = 0, done, irq_seen, e;
   logic [15:0] dd_o, mdma_min_ns_i = 16'h0078, mdma_rec_ns_i = 16'h0096, pio_min_ns_i = 16'h00b4;
   logic [15:0] pio_iordy_ns_i = 16'h0078, pkt_rel_ns_i = 16'h1234, svc_bsy_ns_i = 16'h8765;
   logic [15:0] major_i = 16'h80ff, minor_i = 16'h0017, cmd_sup_i = 16'hffff;
   logic [15:0] cmd_sup2_i = 16'hffff, cmd_ena_i = 16'hffff;
   logic [2:0] mdma_sup_i = 3'h7;
   logic [1:0] mdma_mode_i = 2'h2;
   logic mdma_en_i = 1'b1;
   logic [7:0] pio_sup_i = 8'h03;
   logic [4:0] qdepth_m1_i = 5'h1f;
   int miscompares = 0, checked = 0;
   always #25 clk_i = ~clk_i;
   pkid_words DUT (.*);
   pkid_host_model host (.clk_i(clk_i), .start_i(start), .gap_i(gap), .drq_i(drq_o), .intrq_i(intrq_o),
      .dd_i(dd_o), .ident_cmd_o(ident_cmd_i), .data_rd_o(data_rd_i), .done_o(done), .irq_seen_o(irq_seen));
   // ********************
   // expected image and helpers
   // ********************
   function automatic logic [15:0] exp_word(input int i);
      logic [2:0] s;
      s = (mdma_en_i && (mdma_sup_i >> mdma_mode_i) != 3'h0) ? 3'h1 << mdma_mode_i : 3'h0;
      case (i)
         63: return {5'h0, s, 5'h0, mdma_sup_i};
         64: return {8'h0, pio_sup_i};
         65: return mdma_min_ns_i;
         66: return mdma_rec_ns_i;
         67: return pio_min_ns_i;
         68: return pio_iordy_ns_i;
         71: return pkt_rel_ns_i;
         72: return svc_bsy_ns_i;
         75: return {11'h0, qdepth_m1_i};
         80: return (major_i == 16'h0000 || major_i == 16'hffff) ? major_i : major_i & 16'h003c;
         81: return minor_i;
         82: return cmd_sup_i & 16'h67fb;
         83: return (cmd_sup2_i & 16'h0031) | 16'h4000;
         84: return 16'h4000;
         85: return cmd_ena_i & 16'h67fb;
         default: return 16'h0000;
      endcase
   endfunction
   task automatic report_and_stop;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      wb_adr_i <= a;
      wb_we_i  <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         miscompares++;
         report_and_stop();
      end
      q = wb_dat_o;
      e = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic chk_img;
      for (int i = 63; i <= 85; i++)
      begin
         wb(32'h4, 1'b1, i);
         wb(32'h8, 1'b0, 0);
         cmp($sformatf("word %0d", i), {16'h0, exp_word(i)}, q);
      end
   endtask
   // ********************
   // main sequence
   // ********************
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(32'h4, 1'b0, 0);
      cmp("index reset", 32'h3f, q);
      wb(32'hc, 1'b0, 0);
      cmp("status reset", 32'h0, q);
      wb(32'h10, 1'b0, 0);
      cmp("unmapped err", 32'h1, {31'h0, e});
      $display("test registers done");
      // modes, unsupported and disabled selection, version and set edges
      for (int k = 0; k < 7; k++)
      begin
         mdma_mode_i <= (k == 6) ? 2'h3 : 2'(k % 3);
         mdma_sup_i  <= (k == 3) ? 3'h4 : (k == 5) ? 3'h1 : 3'h7;
         mdma_en_i   <= (k != 4);
         major_i     <= (k == 1) ? 16'h0000 : (k == 2) ? 16'hffff : 16'h80ff;
         minor_i     <= (k == 1) ? 16'h0000 : 16'hffff;
         cmd_sup_i   <= (k == 5) ? 16'h0000 : 16'hffff;
         cmd_sup2_i  <= (k == 5) ? 16'h0000 : 16'hffff;
         @(posedge clk_i);
         chk_img();
      end
      $display("test image done");
      // prompt host with interrupts, then slow host without
      for (int r = 0; r < 2; r++)
      begin
         int_dis_i <= r[0];
         gap       <= r ? 4'h4 : 4'h0;
         start     <= 1'b1;
         @(posedge clk_i);
         start <= 1'b0;
         repeat (2) @(posedge clk_i);
         for (int n = 0; n < 4000 && done !== 1'b1; n++)
            @(posedge clk_i);
         if (done !== 1'b1)
         begin
            miscompares++;
            report_and_stop();
         end
         for (int i = 63; i <= 85; i++)
            cmp($sformatf("read word %0d", i), {16'h0, exp_word(i)}, {16'h0, host.img[i]});
         cmp("irq seen", {31'h0, !r[0]}, {31'h0, irq_seen});
         cmp("drq after", 32'h0, {30'h0, drq_o, intrq_o});
         $display("test identify %0d done", r);
      end
      report_and_stop();
   end
endmodule // packet_identify_words_63_85_test
